/* File: pkg/sam_pkg.sv */
// Purpose: Shared constants and types for the SPI address map register bank.
// Assumes: Six-bit register address space behind a one-byte SPI header.
// Notes: Every offset, field position and reset value is named here once.
package sam_pkg;
	// ==========================================================
	// Header layout and access-type offsets
	localparam int SAM_ADDR_W = 6;
	localparam int SAM_HDR_READ_BIT = 7;
	localparam int SAM_HDR_BURST_BIT = 6;
	localparam logic [7:0] SAM_ACC_SINGLE_WR = 8'h00;
	localparam logic [7:0] SAM_ACC_BURST_WR = 8'h40;
	localparam logic [7:0] SAM_ACC_SINGLE_RD = 8'h80;
	localparam logic [7:0] SAM_ACC_BURST_RD = 8'hc0;

	// ==========================================================
	// Address map
	localparam logic [5:0] SAM_PIN2_OFS = 6'h00;
	localparam logic [5:0] SAM_PIN1_OFS = 6'h01;
	localparam logic [5:0] SAM_PIN0_OFS = 6'h02;
	localparam logic [5:0] SAM_CFG_LAST = 6'h2e;
	localparam int SAM_CFG_COUNT = 47;
	localparam logic [5:0] SAM_STROBE_FIRST = 6'h30;
	localparam logic [5:0] SAM_STROBE_LAST = 6'h3d;
	localparam logic [5:0] SAM_PA_TABLE_OFS = 6'h3e;
	localparam logic [5:0] SAM_FIFO_OFS = 6'h3f;
	localparam logic [5:0] SAM_PART_NUMBER_OFS = 6'h30;
	localparam logic [5:0] SAM_VERSION_OFS = 6'h31;
	localparam logic [5:0] SAM_FREQ_EST_OFS = 6'h32;
	localparam logic [5:0] SAM_CRC_OFS = 6'h33;
	localparam logic [5:0] SAM_SIG_STRENGTH_OFS = 6'h34;
	localparam logic [5:0] SAM_RADIO_STATE_OFS = 6'h35;
	localparam logic [5:0] SAM_PACKET_STATUS_OFS = 6'h38;
	localparam logic [5:0] SAM_TX_BYTES_OFS = 6'h3a;
	localparam logic [5:0] SAM_RX_BYTES_OFS = 6'h3b;

	// ==========================================================
	// Command strobes, indexed by address minus the first strobe address
	localparam int SAM_STROBE_W = 14;
	localparam int SAM_STB_RESET = 0;
	localparam int SAM_STB_SYNTH_ON = 1;
	localparam int SAM_STB_OSC_OFF = 2;
	localparam int SAM_STB_CALIBRATE = 3;
	localparam int SAM_STB_RECEIVE = 4;
	localparam int SAM_STB_TRANSMIT = 5;
	localparam int SAM_STB_GO_IDLE = 6;
	localparam int SAM_STB_POWER_DOWN = 9;
	localparam int SAM_STB_FLUSH_RX = 10;
	localparam int SAM_STB_FLUSH_TX = 11;
	localparam int SAM_STB_NO_OP = 13;
	localparam logic [13:0] SAM_STROBE_VALID = 14'h2e7f;

	// ==========================================================
	// Pin configuration fields and reset values
	localparam int SAM_INV_BIT = 6;
	localparam int SAM_DS_BIT = 7;
	localparam int SAM_UNUSED_BIT = 7;
	localparam logic [7:0] SAM_PIN2_RESET = 8'h29;
	localparam logic [7:0] SAM_PIN1_RESET = 8'h2e;
	localparam logic [7:0] SAM_PIN0_RESET = 8'h3f;
	localparam logic [7:0] SAM_CFG_OTHER_RESET = 8'h00;
	localparam int SAM_PA_DEPTH = 8;

	// ==========================================================
	// Types
	typedef enum logic [5:0] {
		SAM_K_NONE = 6'h01,
		SAM_K_CFG = 6'h02,
		SAM_K_STROBE = 6'h04,
		SAM_K_STATUS = 6'h08,
		SAM_K_PA = 6'h10,
		SAM_K_FIFO = 6'h20
	} sam_kind_e;

	typedef enum logic [2:0] {
		SAM_ST_HDR = 3'h1,
		SAM_ST_DATA = 3'h2,
		SAM_ST_DONE = 3'h4
	} sam_state_e;

	function automatic logic [7:0] sam_cfg_reset(input int idx);
		if (idx == int'(SAM_PIN2_OFS)) begin
			return SAM_PIN2_RESET;
		end else if (idx == int'(SAM_PIN1_OFS)) begin
			return SAM_PIN1_RESET;
		end else if (idx == int'(SAM_PIN0_OFS)) begin
			return SAM_PIN0_RESET;
		end
		return SAM_CFG_OTHER_RESET;
	endfunction
endpackage

/* File: pkg/sam_dec_if.sv */
// Purpose: Carries a header's address and access type to the decoder and the kind back.
// Assumes: Purely combinational path inside one clock domain.
// Notes: None.
`timescale 1ns/1ps
interface sam_dec_if import sam_pkg::*; ();
	logic [5:0] addr;
	logic is_read;
	logic is_burst;
	sam_kind_e kind;
	modport decoder(input addr, input is_read, input is_burst, output kind);
	modport user(output addr, output is_read, output is_burst, input kind);
endinterface

/* File: rtl/sam_decode.sv */
// Purpose: Classifies an address and access type into the kind of target it reaches.
// Assumes: Address and access bits are stable in the cycle they are read.
// Notes: Burst writes into the strobe range reach nothing.
`timescale 1ns/1ps
module sam_decode
	import sam_pkg::*;
(
	// Decode request and result
	sam_dec_if.decoder dec
);
	logic [3:0] stb_idx;

	// ==========================================================
	// Address classification
	always_comb begin
		stb_idx = 4'(dec.addr - SAM_STROBE_FIRST);
		dec.kind = SAM_K_NONE;
		if (dec.addr <= SAM_CFG_LAST) begin
			dec.kind = SAM_K_CFG;
		end else if (dec.addr >= SAM_STROBE_FIRST && dec.addr <= SAM_STROBE_LAST) begin
			if (dec.is_burst) begin
				dec.kind = dec.is_read ? SAM_K_STATUS : SAM_K_NONE;
			end else if (SAM_STROBE_VALID[stb_idx]) begin
				dec.kind = SAM_K_STROBE;
			end
		end else if (dec.addr == SAM_PA_TABLE_OFS) begin
			dec.kind = SAM_K_PA;
		end else if (dec.addr == SAM_FIFO_OFS) begin
			dec.kind = SAM_K_FIFO;
		end
	end
endmodule // sam_decode

/* File: rtl/sam_regbank.sv */
// Purpose: SPI slave that decodes the address space into registers, strobes, status and FIFO ports.
// Assumes: SPI mode 0, clk at least eight times faster than the serial clock.
// Notes: All SPI pins are synchronised, so the serial clock is sampled, not used as a clock.
//
// Operation
// - Header adds 0x00/0x40/0x80/0xC0 access offsets.
// - Sixty-four addresses decoded from the header.
// - Single accesses in upper range are strobes, bar 0x37/0x38/0x3C.
// - 0x30 reset strobe, 0x31 synth on strobe.
// - Burst reads return packet, tx, rx status.
// - 0x3E reaches power table in every mode.
// - 0x3F writes push tx, reads pop rx.
// - Configuration registers keep contents during sleep.
// - Bit 6 inverts each pin, resets zero.
// - Pin 2 selects chip ready; bit7 reads zero.
// - Pin 1 select resets to high impedance.
// - Pin 1 bit 7 sets drive strength.
// - Pin 0 select resets to clock/192.
`timescale 1ns/1ps
module sam_regbank
	import sam_pkg::*;
#(
	parameter int PA_DEPTH = SAM_PA_DEPTH,
	parameter logic [7:0] PART_NUMBER = 8'h00,
	parameter logic [7:0] VERSION = 8'h01
)(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// SPI pins
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Pin configuration
	output logic [7:0] pin2_output_config,
	output logic [7:0] pin1_output_config,
	output logic [7:0] pin0_output_config,
	output logic [PA_DEPTH*8-1:0] power_amp_table,
	// Command strobes
	output logic [SAM_STROBE_W-1:0] command_strobe,
	// FIFO ports
	output logic tx_push,
	output logic [7:0] tx_data,
	output logic rx_pop,
	input wire logic [7:0] rx_data,
	// Status inputs
	input wire logic [7:0] frequency_offset_estimate,
	input wire logic [7:0] crc_status,
	input wire logic [7:0] signal_strength_status,
	input wire logic [7:0] radio_state_status,
	input wire logic [7:0] packet_status,
	input wire logic [7:0] tx_byte_count,
	input wire logic [7:0] rx_byte_count
);
	localparam int PA_IDX_W = (PA_DEPTH > 1) ? $clog2(PA_DEPTH) : 1;

	// ==========================================================
	// Pin synchronisers and edge detection
	logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
	logic cs_s1_r, cs_s2_r;
	logic mosi_s1_r, mosi_s2_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sclk_s1_r <= 1'b0;
			sclk_s2_r <= 1'b0;
			sclk_s3_r <= 1'b0;
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			mosi_s1_r <= 1'b0;
			mosi_s2_r <= 1'b0;
		end else begin
			sclk_s1_r <= spi_sclk;
			sclk_s2_r <= sclk_s1_r;
			sclk_s3_r <= sclk_s2_r;
			cs_s1_r <= spi_cs_n;
			cs_s2_r <= cs_s1_r;
			mosi_s1_r <= spi_mosi;
			mosi_s2_r <= mosi_s1_r;
		end
	end

	logic cs_act, sclk_rise, sclk_fall, byte_done;
	logic [2:0] bit_cnt_r;
	logic [6:0] in_shift_r;
	logic [7:0] byte_in;
	assign cs_act = ~cs_s2_r;
	assign sclk_rise = cs_act & sclk_s2_r & ~sclk_s3_r;
	assign sclk_fall = cs_act & ~sclk_s2_r & sclk_s3_r;
	assign byte_in = {in_shift_r, mosi_s2_r};
	assign byte_done = sclk_rise && (bit_cnt_r == 3'h7);

	// ==========================================================
	// Byte assembly
	always_ff @(posedge clk) begin
		if (sys_rst || !cs_act) begin
			bit_cnt_r <= 3'h0;
			in_shift_r <= 7'h00;
		end else if (sclk_rise) begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			in_shift_r <= byte_in[6:0];
		end
	end

	// ==========================================================
	// Header capture and decode
	sam_state_e st_r;
	logic [5:0] addr_r;
	logic rd_r, burst_r;
	logic [PA_IDX_W-1:0] pa_idx_r;
	sam_dec_if dec();
	logic hdr_done, data_done;
	assign hdr_done = byte_done && (st_r == SAM_ST_HDR);
	assign data_done = byte_done && (st_r == SAM_ST_DATA);
	// The decoder looks at the live header byte so that strobes, the rx pop and the next state are decided as the header completes.
	assign dec.addr = (st_r == SAM_ST_HDR) ? byte_in[5:0] : addr_r;
	assign dec.is_read = (st_r == SAM_ST_HDR) ? byte_in[SAM_HDR_READ_BIT] : rd_r;
	assign dec.is_burst = (st_r == SAM_ST_HDR) ? byte_in[SAM_HDR_BURST_BIT] : burst_r;

	sam_decode u_decode (
		.dec(dec)
	);

	logic next_in_cfg;
	logic [5:0] addr_nxt;
	logic [PA_IDX_W-1:0] pa_idx_nxt;
	assign next_in_cfg = (dec.kind == SAM_K_CFG);
	assign addr_nxt = next_in_cfg ? 6'(addr_r + 6'h01) : addr_r;
	assign pa_idx_nxt = (pa_idx_r == PA_IDX_W'(PA_DEPTH - 1)) ? '0 : PA_IDX_W'(pa_idx_r + 1'b1);

	always_ff @(posedge clk) begin
		if (sys_rst || !cs_act) begin
			st_r <= SAM_ST_HDR;
			addr_r <= 6'h00;
			rd_r <= 1'b0;
			burst_r <= 1'b0;
		end else if (hdr_done) begin
			addr_r <= byte_in[5:0];
			rd_r <= byte_in[SAM_HDR_READ_BIT];
			burst_r <= byte_in[SAM_HDR_BURST_BIT];
			st_r <= (dec.kind == SAM_K_STROBE) ? SAM_ST_DONE : SAM_ST_DATA;
		end else if (data_done) begin
			addr_r <= addr_nxt;
			st_r <= burst_r ? SAM_ST_DATA : SAM_ST_DONE;
		end
	end

	// ==========================================================
	// Power table index, restarted at every chip select
	always_ff @(posedge clk) begin
		if (sys_rst || !cs_act) begin
			pa_idx_r <= '0;
		end else if (data_done && dec.kind == SAM_K_PA) begin
			pa_idx_r <= pa_idx_nxt;
		end
	end

	// ==========================================================
	// Command strobes
	logic [3:0] stb_idx;
	assign stb_idx = 4'(byte_in[5:0] - SAM_STROBE_FIRST);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			command_strobe <= '0;
		end else begin
			command_strobe <= '0;
			if (hdr_done && dec.kind == SAM_K_STROBE) begin
				command_strobe[stb_idx] <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Configuration registers
	// Only a reset clears them; no sleep input exists, so contents survive sleep.
	logic [7:0] cfg_r [SAM_CFG_COUNT];
	logic cfg_wr, cfg_clr;
	assign cfg_wr = data_done && !rd_r && dec.kind == SAM_K_CFG;
	assign cfg_clr = hdr_done && dec.kind == SAM_K_STROBE && stb_idx == 4'(SAM_STB_RESET);
	always_ff @(posedge clk) begin
		if (sys_rst || cfg_clr) begin
			for (int i = 0; i < SAM_CFG_COUNT; i++) begin
				cfg_r[i] <= sam_cfg_reset(i);
			end
		end else if (cfg_wr) begin
			cfg_r[addr_r] <= byte_in;
			if (addr_r == SAM_PIN2_OFS) begin
				cfg_r[addr_r][SAM_UNUSED_BIT] <= 1'b0;
			end
		end
	end
	assign pin2_output_config = cfg_r[SAM_PIN2_OFS];
	assign pin1_output_config = cfg_r[SAM_PIN1_OFS];
	// The clock output stays on until the host turns it off during its own setup.
	assign pin0_output_config = cfg_r[SAM_PIN0_OFS];

	// ==========================================================
	// Power table and transmit FIFO writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_amp_table <= '0;
		end else if (data_done && !rd_r && dec.kind == SAM_K_PA) begin
			power_amp_table[pa_idx_r*8 +: 8] <= byte_in;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_push <= 1'b0;
			tx_data <= 8'h00;
		end else begin
			tx_push <= data_done && !rd_r && dec.kind == SAM_K_FIFO;
			if (data_done && !rd_r && dec.kind == SAM_K_FIFO) begin
				tx_data <= byte_in;
			end
		end
	end

	// ==========================================================
	// Read path
	function automatic logic [7:0] read_byte(input logic [5:0] a, input logic burst,
			input logic [PA_IDX_W-1:0] pi);
		logic [7:0] v;
		v = 8'h00;
		if (a <= SAM_CFG_LAST) begin
			v = cfg_r[a];
		end else if (a == SAM_PA_TABLE_OFS) begin
			v = power_amp_table[pi*8 +: 8];
		end else if (a == SAM_FIFO_OFS) begin
			v = rx_data;
		end else if (burst) begin
			case (a)
				SAM_PART_NUMBER_OFS: v = PART_NUMBER;
				SAM_VERSION_OFS: v = VERSION;
				SAM_FREQ_EST_OFS: v = frequency_offset_estimate;
				SAM_CRC_OFS: v = crc_status;
				SAM_SIG_STRENGTH_OFS: v = signal_strength_status;
				SAM_RADIO_STATE_OFS: v = radio_state_status;
				SAM_PACKET_STATUS_OFS: v = packet_status;
				SAM_TX_BYTES_OFS: v = tx_byte_count;
				SAM_RX_BYTES_OFS: v = rx_byte_count;
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction

	logic load_hdr, load_next;
	logic [7:0] out_shift_r, load_val;
	assign load_hdr = hdr_done && byte_in[SAM_HDR_READ_BIT];
	assign load_next = data_done && rd_r && burst_r;

	always_comb begin
		load_val = read_byte(addr_nxt, 1'b1, (dec.kind == SAM_K_PA) ? pa_idx_nxt : pa_idx_r);
		if (load_hdr) begin
			load_val = read_byte(byte_in[5:0], byte_in[SAM_HDR_BURST_BIT], pa_idx_r);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_shift_r <= 8'h00;
			spi_miso <= 1'b0;
			rx_pop <= 1'b0;
		end else begin
			rx_pop <= (load_hdr || load_next) && dec.kind == SAM_K_FIFO;
			if (load_hdr || load_next) begin
				out_shift_r <= load_val;
				spi_miso <= load_val[7];
			end else if (sclk_fall && bit_cnt_r != 3'h0) begin
				// A byte's first bit must stand through the fall that closes the byte before it.
				out_shift_r <= {out_shift_r[6:0], 1'b0};
				spi_miso <= out_shift_r[6];
			end else if (!cs_act) begin
				out_shift_r <= 8'h00;
				spi_miso <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			spi_miso_oe <= 1'b0;
		end else begin
			spi_miso_oe <= cs_act;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_hdr(logic [7:0] h);
		hdr_done && byte_in == h;
	endsequence
	sequence s_wr_data(sam_kind_e k);
		data_done && !rd_r && dec.kind == k;
	endsequence

	chk_strobe_onehot: assert property ($onehot0(command_strobe)) else $error("two strobes at once");
	chk_strobe_pulse: assert property (command_strobe != '0 |=> command_strobe == '0) else $error("strobe held");
	chk_reset_strobe: assert property (s_hdr(SAM_ACC_SINGLE_WR | SAM_STROBE_FIRST) |=> command_strobe[SAM_STB_RESET]
		##1 pin1_output_config == SAM_PIN1_RESET) else $error("reset strobe missing");
	chk_synth_strobe: assert property (s_hdr(SAM_ACC_SINGLE_RD | SAM_VERSION_OFS) |=> command_strobe[SAM_STB_SYNTH_ON])
		else $error("synth strobe missing");
	chk_reserved_strobe: assert property (s_hdr(SAM_ACC_SINGLE_WR | 8'h37) |=> command_strobe == '0)
		else $error("reserved strobe fired");
	chk_burst_nostrobe: assert property (s_hdr(SAM_ACC_BURST_RD | SAM_PART_NUMBER_OFS) |=> command_strobe == '0
		&& out_shift_r == PART_NUMBER) else $error("burst read not status");
	chk_packet_status: assert property (s_hdr(SAM_ACC_BURST_RD | SAM_PACKET_STATUS_OFS) |=>
		out_shift_r == $past(packet_status)) else $error("packet status wrong");
	chk_hdr_capture: assert property (hdr_done |=> addr_r == $past(byte_in[5:0]) && rd_r == $past(byte_in[7])
		&& burst_r == $past(byte_in[6])) else $error("header not captured");
	chk_tx_push: assert property (s_wr_data(SAM_K_FIFO) |=> tx_push && tx_data == $past(byte_in) ##1 !tx_push)
		else $error("tx push wrong");
	chk_rx_pop: assert property (s_hdr(SAM_ACC_SINGLE_RD | SAM_FIFO_OFS) |=> rx_pop) else $error("rx pop missing");
	chk_pa_index: assert property (s_wr_data(SAM_K_PA) |=> pa_idx_r != $past(pa_idx_r) || PA_DEPTH == 1)
		else $error("power table index stuck");
	chk_pin2_unused: assert property (pin2_output_config[SAM_UNUSED_BIT] == 1'b0) else $error("pin2 bit7 set");
	chk_cfg_defaults: assert property ($fell(sys_rst) |-> pin2_output_config == SAM_PIN2_RESET
		&& pin1_output_config == SAM_PIN1_RESET && pin0_output_config == SAM_PIN0_RESET)
		else $error("pin config reset wrong");
	chk_cfg_keep: assert property (!cfg_wr && !cfg_clr |=> $stable(pin0_output_config))
		else $error("config changed unasked");
endmodule // sam_regbank

/* File: sim/sam_spi_host.sv */
// Purpose: SPI host model that frames headers and data bytes in mode 0.
// Assumes: sclk high for eight clk cycles and low for at least nine, inside the clk/8 limit.
// Notes: sclk stands low between frames; a released mosi shows its inverse.
`timescale 1ns/1ps
module sam_spi_host (
	// Clock
	input wire logic clk,
	// SPI pins
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	localparam int HALF = 8;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ==========================================================
	// Frame control
	task automatic open_frame();
		@(negedge clk);
		cs_n <= 1'b0;
		repeat (HALF) @(negedge clk);
	endtask

	task automatic close_frame();
		repeat (HALF) @(negedge clk);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (4 * HALF) @(negedge clk);
	endtask

	// Bits go out MSB first; a bit read while the device is not driving is unknown.
	task automatic shift(input logic [7:0] wb, input int nb, output logic [7:0] rb);
		rb = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			@(negedge clk);
			mosi <= wb[i];
			repeat (HALF) @(negedge clk);
			rb[i] = (miso_oe === 1'b1) ? miso : 1'bx;
			sclk <= 1'b1;
			repeat (HALF) @(negedge clk);
			sclk <= 1'b0;
		end
	endtask
endmodule // sam_spi_host

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the SPI address map register bank.
// Assumes: Status inputs and receive FIFO head are modelled by the bench.
// Notes: Identification parameters carry arbitrary values.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top import sam_pkg::*;;
	// ==========================================================
	// Constants and rows
	localparam logic [7:0] PARTNO = 8'h5c; // Arbitrary value.
	localparam logic [7:0] VERNO = 8'h07; // Arbitrary value.
	localparam int CEIL = 60000;
	localparam logic [13:0] VALID = 14'h2e7f;
	localparam logic [7:0] RST [3] = '{8'h29, 8'h2e, 8'h3f};
	localparam logic [7:0] MODES [3] = '{SAM_ACC_SINGLE_WR, SAM_ACC_SINGLE_RD, SAM_ACC_BURST_WR};
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wd;
		logic [7:0] exp;
	} sam_row_s;
	localparam sam_row_s ROWS [6] = '{'{6'h00, 8'hff, 8'h7f}, '{6'h01, 8'hc0, 8'hc0}, '{6'h02, 8'h40, 8'h40},
		'{6'h2e, 8'ha5, 8'ha5}, '{6'h2f, 8'h5a, 8'h00}, '{6'h3e, 8'h33, 8'h33}};

	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sclk, cs_n, mosi, miso, miso_oe, tx_push, rx_pop;
	logic [7:0] pin2, pin1, pin0, tx_data, rx_data, b;
	logic [63:0] pa;
	logic [13:0] stb, stb_acc, exp14;
	logic [7:0] st [7];
	logic [7:0] tx_log [8];
	logic [31:0] rd;
	logic [7:0] rx_rd = 8'h00;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int stb_cyc = 0;
	int tx_n = 0;

	always #2.5 clk = ~clk;
	assign rx_data = 8'he1 + rx_rd;

	sam_spi_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

	sam_regbank #(.PA_DEPTH(8), .PART_NUMBER(PARTNO), .VERSION(VERNO)) uut (
		.clk(clk), .sys_rst(sys_rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
		.spi_miso(miso), .spi_miso_oe(miso_oe), .pin2_output_config(pin2), .pin1_output_config(pin1),
		.pin0_output_config(pin0), .power_amp_table(pa), .command_strobe(stb), .tx_push(tx_push),
		.tx_data(tx_data), .rx_pop(rx_pop), .rx_data(rx_data), .frequency_offset_estimate(st[0]),
		.crc_status(st[1]), .signal_strength_status(st[2]), .radio_state_status(st[3]),
		.packet_status(st[4]), .tx_byte_count(st[5]), .rx_byte_count(st[6]));

	// ==========================================================
	// Monitors
	always @(posedge clk) begin
		cyc <= cyc + 1;
		stb_acc <= stb_acc | stb;
		stb_cyc <= stb_cyc + int'(|stb);
		if (tx_push === 1'b1) begin
			tx_log[tx_n[2:0]] <= tx_data;
			tx_n <= tx_n + 1;
		end
		if (cyc == CEIL) begin
			err_total++;
			results();
		end
	end

	// The FIFO head moves only after the pop, so a late pop shows as a repeated byte.
	always @(negedge clk) begin
		if (rx_pop === 1'b1) begin
			rx_rd <= rx_rd + 8'h01;
		end
	end

	// ==========================================================
	// Tasks
	function automatic logic [7:0] st_exp(input logic [5:0] a);
		case (a)
			6'h30: return PARTNO;
			6'h31: return VERNO;
			6'h32, 6'h33, 6'h34, 6'h35: return st[a - 6'h32];
			6'h38: return st[4];
			6'h3a: return st[5];
			6'h3b: return st[6];
			default: return 8'h00;
		endcase
	endfunction

	task automatic acc(input logic [7:0] hdr, input int n, input logic [31:0] wd, output logic [31:0] r);
		logic [7:0] x;
		r = 32'h0;
		host.open_frame();
		host.shift(hdr, 8, x);
		for (int i = 0; i < n; i++) begin
			host.shift(wd[31-8*i -: 8], 8, x);
			r[31-8*i -: 8] = x;
		end
		host.close_frame();
	endtask

	task automatic results();
		$display("Checks run %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		stb_acc = '0;
		for (int k = 0; k < 7; k++) st[k] = 8'(8'h11 * (k + 1));
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		`CHK({pin2, pin1, pin0, pa}, {24'h292e3f, 64'h0})
		for (int k = 0; k < 3; k++) begin
			acc(SAM_ACC_SINGLE_RD | 8'(k), 1, 32'h0, rd);
			`CHK(rd[31:24], RST[k])
		end
		foreach (ROWS[i]) begin
			acc(SAM_ACC_SINGLE_WR | {2'b00, ROWS[i].addr}, 1, {ROWS[i].wd, 24'h0}, rd);
			acc(SAM_ACC_SINGLE_RD | {2'b00, ROWS[i].addr}, 1, 32'h0, rd);
			`CHK(rd[31:24], ROWS[i].exp)
		end
		`CHK({pin2, pin1, pin0, pa[7:0]}, 32'h7fc04033)
		for (int a = 8'h30; a <= 8'h3d; a++) begin
			for (int m = 0; m < 3; m++) begin
				stb_acc = '0;
				stb_cyc = 0;
				acc(MODES[m] | 8'(a), 0, 32'h0, rd);
				exp14 = (m < 2 && VALID[a - 8'h30]) ? 14'(1) << (a - 8'h30) : 14'h0;
				`CHK(stb_acc, exp14)
				`CHK(stb_cyc, int'(|exp14))
			end
		end
		`CHK({pin2, pin1, pin0}, 24'h292e3f)
		for (int a = 8'h30; a <= 8'h3d; a++) begin
			stb_acc = '0;
			acc(SAM_ACC_BURST_RD | 8'(a), 2, 32'h0, rd);
			`CHK(rd[31:16], {2{st_exp(6'(a))}})
			`CHK(stb_acc, 14'h0)
		end
		acc(SAM_ACC_BURST_WR | {2'b00, SAM_PA_TABLE_OFS}, 4, 32'h01020304, rd);
		`CHK(pa[31:0], 32'h04030201)
		acc(SAM_ACC_BURST_RD | {2'b00, SAM_PA_TABLE_OFS}, 4, 32'h0, rd);
		`CHK(rd, 32'h01020304)
		acc(SAM_ACC_BURST_WR, 3, 32'h8a150700, rd);
		`CHK({pin2, pin1, pin0}, 24'h0a1507)
		acc(SAM_ACC_SINGLE_WR | {2'b00, SAM_FIFO_OFS}, 2, 32'h96690000, rd);
		acc(SAM_ACC_BURST_WR | {2'b00, SAM_FIFO_OFS}, 3, 32'ha1b2c300, rd);
		`CHK({tx_log[0], tx_log[1], tx_log[3], 8'(tx_n)}, 32'h96a1c304)
		acc(SAM_ACC_SINGLE_RD | {2'b00, SAM_FIFO_OFS}, 2, 32'h0, rd);
		`CHK({rd[31:24], rx_rd}, 16'he101)
		acc(SAM_ACC_BURST_RD | {2'b00, SAM_FIFO_OFS}, 3, 32'h0, rd);
		`CHK(rd[31:8], 24'he2e3e4)
		host.open_frame();
		host.shift(SAM_ACC_SINGLE_WR | {2'b00, SAM_PIN0_OFS}, 8, b);
		host.shift(8'h55, 4, b);
		host.close_frame();
		`CHK(pin0, 8'h07)
		acc(SAM_ACC_SINGLE_WR | {2'b00, SAM_PIN0_OFS}, 1, 32'h21000000, rd);
		`CHK(pin0, 8'h21)
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		`CHK({pin2, pin1, pin0, pa}, {24'h292e3f, 64'h0})
		results();
	end
endmodule // tb_top
